// file: logic/dcc_pkg.sv
// dual comparator control: register map, field positions, reset values, modes
// assumes an 8-bit register view behind a 32-bit AXI4-Lite slave
package dcc_pkg;
  // byte addresses of the register words
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_FLAG  = 8'h04;
  localparam logic [7:0] ADDR_EN    = 8'h08;
  localparam logic [7:0] ADDR_IRQC  = 8'h0C;
  localparam logic [7:0] ADDR_DIR   = 8'h10;
  localparam logic [7:0] ADDR_ADC1  = 8'h14;
  localparam logic [7:0] ADDR_PORTA = 8'h18;
  // field positions
  localparam int CTRL_RES2 = 7;
  localparam int CTRL_RES1 = 6;
  localparam int CTRL_INV2 = 5;
  localparam int CTRL_INV1 = 4;
  localparam int CTRL_CIS  = 3;
  localparam int FLAG_BIT  = 6;
  localparam int EN_BIT    = 6;
  localparam int GIE_BIT   = 7;
  localparam int PERIPHERAL_IRQ_EN_BIT  = 6;
  // values after reset
  localparam logic [2:0] MODE_RST = 3'h7;
  localparam logic [5:0] DIR_RST  = 6'h3F;
  localparam logic [3:0] PCFG_RST = 4'h0;
  // modes of the mode field
  typedef enum logic [2:0] {
    DCC_RESET_OFF = 3'b000,
    DCC_ONE_OUT   = 3'b001,
    DCC_TWO_IND   = 3'b010,
    DCC_TWO_OUT   = 3'b011,
    DCC_TWO_COM   = 3'b100,
    DCC_COM_OUT   = 3'b101,
    DCC_MUX_REF   = 3'b110,
    DCC_OFF       = 3'b111
  } dcc_mode_t;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // word decode shared by read and write paths
  function automatic logic dcc_is_mapped(input logic [7:0] a);
    dcc_is_mapped = (a[1:0] == 2'h0) && (a <= ADDR_PORTA);
  endfunction : dcc_is_mapped
endpackage : dcc_pkg

// file: logic/dcc_sync.sv
// two-flop synchroniser for pin and comparator levels
// assumes inputs asynchronous to i_sys_clk
`timescale 1ns/100ps
module dcc_sync #(
  parameter int W = 2
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dcc_sync_st_t;
  dcc_sync_st_t s;
  dcc_sync_st_t next_s;

  // first stage only feeds second stage
  always_comb begin
    next_s.meta   = i_async;
    next_s.stable = s.meta;
    if (!i_resetn) begin
      next_s = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    s <= next_s;
  end

  assign o_sync = s.stable;
endmodule : dcc_sync

// file: logic/dcc_mode_decode.sv
// mode decode: comparator power, input muxes, reference and pin routing
// assumes the analog muxes sit outside and follow these selects
`timescale 1ns/100ps
module dcc_mode_decode (
  input  wire logic [2:0] i_mode,
  input  wire logic       i_cis,
  output logic            o_cmp1_on,
  output logic            o_cmp2_on,
  output logic            o_cmp1_neg_hi,
  output logic            o_cmp2_neg_hi,
  output logic            o_ref_to_pos,
  output logic            o_route_pins
);
  // one configuration per mode
  always_comb begin
    o_cmp1_on     = 1'b1;
    o_cmp2_on     = 1'b1;
    o_cmp1_neg_hi = 1'b0;
    o_cmp2_neg_hi = 1'b0;
    o_ref_to_pos  = 1'b0;
    o_route_pins  = 1'b0;
    unique case (dcc_pkg::dcc_mode_t'(i_mode))
      dcc_pkg::DCC_RESET_OFF, dcc_pkg::DCC_OFF: begin
        o_cmp1_on = 1'b0;
        o_cmp2_on = 1'b0;
      end
      dcc_pkg::DCC_ONE_OUT: begin
        o_cmp2_on    = 1'b0;
        o_route_pins = 1'b1;
      end
      dcc_pkg::DCC_TWO_OUT, dcc_pkg::DCC_COM_OUT: begin
        o_route_pins = 1'b1;
      end
      dcc_pkg::DCC_MUX_REF: begin
        o_ref_to_pos  = 1'b1;
        o_cmp1_neg_hi = i_cis;
        o_cmp2_neg_hi = i_cis;
      end
      dcc_pkg::DCC_TWO_IND, dcc_pkg::DCC_TWO_COM: begin
        o_route_pins = 1'b0;
      end
    endcase
  end
endmodule : dcc_mode_decode

// file: logic/dcc_top.sv
// dual comparator control: control register, change flag, pin routing
// assumes AXI4-Lite master on i_sys_clk, raw comparator levels asynchronous
// assumes i_sleep comes from core logic on i_sys_clk and needs no synchroniser
// Behaviour
// - result bits 7 and 6 are read-only
// - result high when positive input exceeds negative
// - bits 5,4 invert result and pin
// - mode 110 input switch picks negative inputs
// - mode field selects eight configurations; the decode treats 000/111, 010/100 and 011/101 alike
// - reset gives mode 111, other bits cleared
// - internal reference only in mode 110
// - routed pins carry unsynchronised results directly
// - direction bits stay pin output enables
// - result change sets change flag
// - flag written zero clears, one sets
// - interrupt only when flag and three enables
// - mismatch keeps setting; control register access ends it
// - change at read moment may be missed; here it is latched and still sets the flag
// - comparators run in sleep; interrupt wakes
// - waking leaves control register unchanged
// - lines 0-3 analog after reset
`timescale 1ns/100ps
module dcc_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_cmp1_raw,
  input  wire logic        i_cmp2_raw,
  input  wire logic [5:0]  i_porta_pins,
  input  wire logic        i_sleep,
  output logic             o_cmp1_on,
  output logic             o_cmp2_on,
  output logic             o_cmp1_neg_hi,
  output logic             o_cmp2_neg_hi,
  output logic             o_ref_to_pos,
  output logic             o_porta_line4,
  output logic             o_porta_line4_oe,
  output logic             o_porta_line5,
  output logic             o_porta_line5_oe,
  output logic             o_cmp_irq,
  output logic             o_wake
);
  // whole module state: bus slave halves, control fields, change logic
  typedef struct packed {
    logic       aw_have;
    logic       w_have;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic       wlane;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic       inv2;
    logic       inv1;
    logic       input_switch_sel;
    logic [2:0] mode;
    logic [1:0] latched;
    logic       flag;
    logic       cmp_change_irq_en;
    logic       peripheral_irq_en;
    logic       global_irq_en;
    logic [5:0] dir;
    logic [3:0] pcfg;
  } dcc_st_t;
  dcc_st_t s;
  dcc_st_t next_s;

  // values derived from the state every cycle
  logic [1:0] res_sync;
  logic [5:0] pins_sync;
  logic [1:0] live;
  logic       mismatch;
  logic       do_write;
  logic       do_read;
  logic       ctrl_access;
  logic       route_pins;
  logic [5:0] analog_mask;

  // comparator results into the clock domain
  dcc_sync #(.W(2)) u_res_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   ({i_cmp2_raw, i_cmp1_raw}),
    .o_sync    (res_sync)
  );

  // port pins for port reads
  dcc_sync #(.W(6)) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_porta_pins),
    .o_sync    (pins_sync)
  );

  // mode decode drives comparator power and analog mux selects
  dcc_mode_decode u_decode (
    .i_mode        (s.mode),
    .i_cis         (s.input_switch_sel),
    .o_cmp1_on     (o_cmp1_on),
    .o_cmp2_on     (o_cmp2_on),
    .o_cmp1_neg_hi (o_cmp1_neg_hi),
    .o_cmp2_neg_hi (o_cmp2_neg_hi),
    .o_ref_to_pos  (o_ref_to_pos),
    .o_route_pins  (route_pins)
  );

  // live results: raw polarity, inverted on request, zero when powered down
  assign live[0] = o_cmp1_on & (res_sync[0] ^ s.inv1);
  assign live[1] = o_cmp2_on & (res_sync[1] ^ s.inv2);
  // any difference from the latched pair is a pending change
  assign mismatch = (live != s.latched);

  // pins take the raw comparator level, no flops in the path
  // a direction bit of one means input, so the pin stays released
  assign o_porta_line4    = route_pins & (i_cmp1_raw ^ s.inv1);
  assign o_porta_line5    = route_pins & (i_cmp2_raw ^ s.inv2);
  assign o_porta_line4_oe = route_pins & ~s.dir[4];
  assign o_porta_line5_oe = route_pins & ~s.dir[5];

  // lines 0-3 analog while k + cfg < 4
  always_comb begin
    analog_mask = '0;
    for (int k = 0; k < 4; k++) begin
      analog_mask[k] = ({2'b00, s.pcfg} + 6'(k)) < 6'h04;
    end
  end

  // interrupt gating and wake; sleep never touches the registers
  assign o_cmp_irq = s.flag & s.cmp_change_irq_en & s.peripheral_irq_en & s.global_irq_en;
  assign o_wake    = i_sleep & s.flag & s.cmp_change_irq_en;

  // bus handshakes
  assign o_awready = ~s.aw_have & ~s.bvalid;
  assign o_wready  = ~s.w_have & ~s.bvalid;
  assign o_arready = ~s.rvalid;
  // answers come straight from registered state
  assign o_bvalid  = s.bvalid;
  assign o_bresp   = s.bresp;
  assign o_rvalid  = s.rvalid;
  assign o_rresp   = s.rresp;
  assign o_rdata   = {24'h000000, s.rdata};

  // a write applies once both halves are held and no answer is pending
  assign do_write    = s.aw_have & s.w_have & ~s.bvalid;
  assign do_read     = i_arvalid & o_arready;
  assign ctrl_access = (do_write & (s.waddr == dcc_pkg::ADDR_CTRL))
                     | (do_read & (i_araddr == dcc_pkg::ADDR_CTRL));

  // next state of bus slave and registers
  always_comb begin
    next_s = s;
    // capture address and data in either order
    if (i_awvalid & o_awready) begin
      next_s.aw_have = 1'b1;
      next_s.waddr   = i_awaddr;
    end
    if (i_wvalid & o_wready) begin
      next_s.w_have = 1'b1;
      next_s.wdata  = i_wdata[7:0];
      next_s.wlane  = i_wstrb[0];
    end
    // answers drop at the edge that hands them over
    if (s.bvalid & i_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid & i_rready) begin
      next_s.rvalid = 1'b0;
    end
    // write takes effect once both halves are held
    if (do_write) begin
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = dcc_pkg::dcc_is_mapped(s.waddr) ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
      // a cleared lane strobe leaves every register as it is
      if (s.wlane) begin
        unique case (s.waddr)
          dcc_pkg::ADDR_CTRL: begin
            next_s.inv2 = s.wdata[dcc_pkg::CTRL_INV2]; // bits 7:6 dropped
            next_s.inv1 = s.wdata[dcc_pkg::CTRL_INV1];
            next_s.input_switch_sel  = s.wdata[dcc_pkg::CTRL_CIS];
            next_s.mode = s.wdata[2:0];
          end
          dcc_pkg::ADDR_FLAG: next_s.flag = s.wdata[dcc_pkg::FLAG_BIT];
          dcc_pkg::ADDR_EN:   next_s.cmp_change_irq_en = s.wdata[dcc_pkg::EN_BIT];
          dcc_pkg::ADDR_IRQC: begin
            next_s.global_irq_en  = s.wdata[dcc_pkg::GIE_BIT];
            next_s.peripheral_irq_en = s.wdata[dcc_pkg::PERIPHERAL_IRQ_EN_BIT];
          end
          dcc_pkg::ADDR_DIR:  next_s.dir  = s.wdata[5:0];
          dcc_pkg::ADDR_ADC1: next_s.pcfg = s.wdata[3:0];
          default: ;
        endcase
      end
    end
    // read data captured at acceptance
    if (do_read) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = dcc_pkg::dcc_is_mapped(i_araddr) ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
      // unmapped or unaligned words read as zero
      unique case (i_araddr)
        dcc_pkg::ADDR_CTRL:  next_s.rdata = {live[1], live[0], s.inv2, s.inv1, s.input_switch_sel, s.mode};
        dcc_pkg::ADDR_FLAG:  next_s.rdata = {1'b0, s.flag, 6'h00};
        dcc_pkg::ADDR_EN:    next_s.rdata = {1'b0, s.cmp_change_irq_en, 6'h00};
        dcc_pkg::ADDR_IRQC:  next_s.rdata = {s.global_irq_en, s.peripheral_irq_en, 6'h00};
        dcc_pkg::ADDR_DIR:   next_s.rdata = {2'b00, s.dir};
        dcc_pkg::ADDR_ADC1:  next_s.rdata = {4'h0, s.pcfg};
        dcc_pkg::ADDR_PORTA: next_s.rdata = {2'b00, pins_sync & ~analog_mask};
        default:             next_s.rdata = 8'h00;
      endcase
    end
    // any control access re-latches the results; a change in that same
    // cycle is latched but still sets the flag through the mismatch
    if (ctrl_access) begin
      next_s.latched = live;
    end
    // mismatch sets the flag and wins over a software clear
    if (mismatch) begin
      next_s.flag = 1'b1;
    end
    // reset last, so it overrides every bus and change update
    if (!i_resetn) begin
      next_s      = '0;
      next_s.mode = dcc_pkg::MODE_RST;
      next_s.dir  = dcc_pkg::DIR_RST;
      next_s.pcfg = dcc_pkg::PCFG_RST;
    end
  end

  // one register stage for the whole state
  always_ff @(posedge i_sys_clk) begin
    s <= next_s;
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  // bus steps that the change logic reacts to
  sequence ctrl_read_s;
    do_read && (i_araddr == dcc_pkg::ADDR_CTRL);
  endsequence
  sequence flag_clear_s;
    do_write && s.wlane && (s.waddr == dcc_pkg::ADDR_FLAG) && !s.wdata[dcc_pkg::FLAG_BIT];
  endsequence
  sequence flag_set_s;
    do_write && s.wlane && (s.waddr == dcc_pkg::ADDR_FLAG) && s.wdata[dcc_pkg::FLAG_BIT];
  endsequence
  sequence ctrl_write_s;
    do_write && s.wlane && (s.waddr == dcc_pkg::ADDR_CTRL);
  endsequence

  // control register: reset state, read-only results, written fields
  ctrl_reset_a: assert property ($past(!i_resetn) |-> s.mode == 3'h7 && !s.inv1 && !s.inv2 && !s.input_switch_sel)
    else $error("control register not at reset state");
  result_read_a: assert property (ctrl_read_s |=> o_rdata[7:6] == $past(live) && o_rvalid)
    else $error("result bits read wrong");
  ctrl_write_a: assert property (ctrl_write_s |=> {s.inv2, s.inv1, s.input_switch_sel, s.mode} == s.wdata[5:0])
    else $error("control fields not taken from write");

  // mode decode
  ref_mode_a: assert property (o_ref_to_pos |-> s.mode == 3'h6)
    else $error("reference routed outside mode 110");
  ref_on_a: assert property (s.mode == 3'h6 |-> o_ref_to_pos && !route_pins)
    else $error("reference missing in mode 110");
  mode_off_a: assert property (s.mode == dcc_pkg::MODE_RST |-> !o_cmp1_on && !o_cmp2_on && !route_pins)
    else $error("comparators on in off mode");
  one_out_a: assert property (s.mode == 3'h1 |-> o_cmp1_on && !o_cmp2_on && route_pins)
    else $error("single comparator mode wrong");
  two_out_a: assert property (s.mode == 3'h3 || s.mode == 3'h5 |-> o_cmp1_on && o_cmp2_on && route_pins)
    else $error("routed two comparator mode wrong");
  two_in_a: assert property (s.mode == 3'h2 || s.mode == 3'h4 |-> o_cmp1_on && o_cmp2_on && !route_pins)
    else $error("unrouted two comparator mode wrong");
  cis_route_a: assert property (s.mode == 3'h6 |-> o_cmp1_neg_hi == s.input_switch_sel && o_cmp2_neg_hi == s.input_switch_sel)
    else $error("input switch not followed");
  neg_default_a: assert property (s.mode != 3'h6 |-> !o_cmp1_neg_hi && !o_cmp2_neg_hi && !o_ref_to_pos)
    else $error("input switch active outside mode 110");

  // pins
  pin_invert_a: assert property (route_pins |-> o_porta_line4 == (i_cmp1_raw ^ s.inv1))
    else $error("pin polarity wrong");
  pin5_invert_a: assert property (route_pins |-> o_porta_line5 == (i_cmp2_raw ^ s.inv2))
    else $error("second pin polarity wrong");
  pin_enable_a: assert property (route_pins && s.dir[5] |-> !o_porta_line5_oe)
    else $error("pin driven while direction is input");
  pin4_enable_a: assert property (route_pins && !s.dir[4] |-> o_porta_line4_oe)
    else $error("routed output pin not enabled");
  pin4_off_a: assert property (route_pins && s.dir[4] |-> !o_porta_line4_oe)
    else $error("first pin driven while direction is input");
  pin_off_a: assert property (!route_pins |-> !o_porta_line4 && !o_porta_line5
                              && !o_porta_line4_oe && !o_porta_line5_oe)
    else $error("pin driven while not routed");

  // change flag, interrupt and sleep
  flag_set_a: assert property (mismatch |=> s.flag)
    else $error("change did not set flag");
  flag_one_a: assert property (flag_set_s |=> s.flag)
    else $error("flag not set by one write");
  access_end_a: assert property ((ctrl_read_s and !do_write) ##1 (res_sync == $past(res_sync))
                                 |-> !mismatch)
    else $error("access did not end mismatch");
  latch_ctrl_a: assert property (ctrl_read_s |=> s.latched == $past(live))
    else $error("control read did not latch results");
  flag_clear_a: assert property ((flag_clear_s and !mismatch) |=> !s.flag)
    else $error("flag not cleared by zero write");
  flag_hold_a: assert property (s.flag && !do_write |=> s.flag)
    else $error("flag lost without a write");
  irq_gate_a: assert property (!s.global_irq_en || !s.peripheral_irq_en || !s.cmp_change_irq_en |-> !o_cmp_irq)
    else $error("interrupt without enables");
  irq_on_a: assert property (s.flag && s.cmp_change_irq_en && s.peripheral_irq_en && s.global_irq_en |-> o_cmp_irq)
    else $error("enabled interrupt not raised");
  wake_a: assert property (i_sleep && s.flag && s.cmp_change_irq_en |-> o_wake)
    else $error("enabled change did not wake");
  wake_off_a: assert property (!i_sleep |-> !o_wake)
    else $error("wake while awake");
  sleep_keep_a: assert property (i_sleep && !do_write
                                 |=> $stable(s.mode) && $stable(s.inv1) && $stable(s.inv2) && $stable(s.input_switch_sel))
    else $error("control register changed in sleep");

  // port reads
  analog_zero_a: assert property (do_read && i_araddr == dcc_pkg::ADDR_PORTA && s.pcfg == 4'h0
                                  |=> o_rdata[3:0] == 4'h0)
    else $error("analog line read nonzero");
  analog_reset_a: assert property (s.pcfg == dcc_pkg::PCFG_RST |-> analog_mask[3:0] == 4'hF)
    else $error("lines 0-3 not analog after reset");
endmodule : dcc_top

// file: testbench/dcc_analog_model.sv
// partner model: analog levels on both comparators and the port pin levels
// assumes the bench commands new levels just after a rising edge
`timescale 1ns/100ps
module dcc_analog_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_c1_pos,
  input  wire logic [7:0] i_c1_neg,
  input  wire logic [7:0] i_c2_pos,
  input  wire logic [7:0] i_c2_neg,
  input  wire logic [5:0] i_pin_lvl,
  output logic            o_cmp1_raw,
  output logic            o_cmp2_raw,
  output logic [5:0]      o_pins
);
  // comparator outputs settle one edge after a new input level
  always_ff @(posedge i_sys_clk) begin
    o_cmp1_raw <= i_c1_pos > i_c1_neg;
    o_cmp2_raw <= i_c2_pos > i_c2_neg;
    o_pins     <= i_pin_lvl;
  end
endmodule : dcc_analog_model

// file: testbench/dual_comparator_control_bench.sv
// bench: register table, change flag, gating, pin routing, mode decode, reset
// assumes dcc_top with AXI4-Lite slave and the analog partner model
`timescale 1ns/100ps
module dual_comparator_control_bench;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} dcc_row_t;
  logic i_sys_clk, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_sleep;
  logic [7:0] i_awaddr, i_araddr, c1p, c1n, c2p, c2n;
  logic [31:0] i_wdata, o_rdata, v;
  logic [3:0] i_wstrb;
  logic [5:0] i_porta_pins, pin_lvl;
  logic [1:0] o_bresp, o_rresp, r;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_cmp1_raw, i_cmp2_raw;
  logic o_cmp1_on, o_cmp2_on, o_cmp1_neg_hi, o_cmp2_neg_hi, o_ref_to_pos, o_cmp_irq, o_wake;
  logic o_porta_line4, o_porta_line4_oe, o_porta_line5, o_porta_line5_oe;
  int miscompares = 0;
  int checked = 0;
  dcc_row_t rows [7] = '{
    '{dcc_pkg::ADDR_CTRL, 32'hC7, 32'h07, dcc_pkg::RESP_OKAY},
    '{dcc_pkg::ADDR_ADC1, 32'h04, 32'h04, dcc_pkg::RESP_OKAY},
    '{dcc_pkg::ADDR_EN, 32'h40, 32'h40, dcc_pkg::RESP_OKAY},
    '{dcc_pkg::ADDR_IRQC, 32'hC0, 32'hC0, dcc_pkg::RESP_OKAY},
    '{dcc_pkg::ADDR_DIR, 32'h0F, 32'h0F, dcc_pkg::RESP_OKAY},
    '{8'h1C, 32'h55, 32'h00, dcc_pkg::RESP_SLVERR},
    '{8'h02, 32'h55, 32'h00, dcc_pkg::RESP_SLVERR}};

  dcc_top u_dcc_top (.i_sys_clk, .i_resetn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_cmp1_raw, .i_cmp2_raw, .i_porta_pins, .i_sleep,
    .o_cmp1_on, .o_cmp2_on, .o_cmp1_neg_hi, .o_cmp2_neg_hi, .o_ref_to_pos, .o_porta_line4,
    .o_porta_line4_oe, .o_porta_line5, .o_porta_line5_oe, .o_cmp_irq, .o_wake);
  dcc_analog_model u_dcc_analog_model (.i_sys_clk, .i_c1_pos(c1p), .i_c1_neg(c1n), .i_c2_pos(c2p),
    .i_c2_neg(c2n), .i_pin_lvl(pin_lvl), .o_cmp1_raw(i_cmp1_raw), .o_cmp2_raw(i_cmp2_raw),
    .o_pins(i_porta_pins));

  // clock, 40 ns period
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // verdict and end of run
  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // compare seen against expected
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one AXI write; ready sampled at the falling edge, acted on at the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ta, tw, tb;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge i_sys_clk);
      ta = i_awvalid && o_awready;
      tw = i_wvalid && o_wready;
      tb = o_bvalid;
      rs = o_bresp;
      @(posedge i_sys_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
      if (tb) return;
    end
    miscompares++;
    wrap_up();
  endtask : wr

  // one AXI read, same sampling scheme
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ta, tr;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge i_sys_clk);
      ta = i_arvalid && o_arready;
      tr = o_rvalid;
      d = o_rdata;
      rs = o_rresp;
      @(posedge i_sys_clk);
      if (ta) i_arvalid <= 1'b0;
      if (tr) return;
    end
    miscompares++;
    wrap_up();
  endtask : rd

  // read one register word and compare it
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v, r);
    chk("readback", v, e);
  endtask : rdchk

  // main sequence
  initial begin
    {i_resetn, i_awvalid, i_wvalid, i_arvalid, i_sleep} = '0;
    {i_bready, i_rready, i_wstrb} = {2'h3, 4'hF};
    {i_awaddr, i_araddr, i_wdata} = '0;
    {c1p, c1n, c2p, c2n, pin_lvl} = {8'hC8, 8'h64, 8'h32, 8'h64, 6'h3F};
    repeat (5) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    @(posedge i_sys_clk);
    rdchk(dcc_pkg::ADDR_CTRL, 32'h07);
    rdchk(dcc_pkg::ADDR_PORTA, 32'h30);
    rdchk(dcc_pkg::ADDR_DIR, 32'h3F);
    // register table rows
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      chk("bresp", 32'(r), 32'(rows[i].r));
      rd(rows[i].a, v, r);
      chk("rdata", v, rows[i].e);
      chk("rresp", 32'(r), 32'(rows[i].r));
    end
    rdchk(dcc_pkg::ADDR_PORTA, 32'h3F);
    // live results, change flag and its gating
    wr(dcc_pkg::ADDR_CTRL, 32'h02, r);
    repeat (4) @(posedge i_sys_clk);
    rdchk(dcc_pkg::ADDR_CTRL, 32'h42);
    wr(dcc_pkg::ADDR_FLAG, 32'h00, r);
    rdchk(dcc_pkg::ADDR_FLAG, 32'h00);
    c2p <= 8'h96;
    repeat (6) @(posedge i_sys_clk);
    chk("irq", 32'(o_cmp_irq), 32'h1);
    wr(dcc_pkg::ADDR_FLAG, 32'h00, r);
    rdchk(dcc_pkg::ADDR_FLAG, 32'h40);
    wr(dcc_pkg::ADDR_IRQC, 32'h80, r);
    chk("irq_gated", 32'(o_cmp_irq), 32'h0);
    rdchk(dcc_pkg::ADDR_CTRL, 32'hC2);
    wr(dcc_pkg::ADDR_FLAG, 32'h00, r);
    rdchk(dcc_pkg::ADDR_FLAG, 32'h00);
    wr(dcc_pkg::ADDR_FLAG, 32'h40, r);
    rdchk(dcc_pkg::ADDR_FLAG, 32'h40);
    i_sleep <= 1'b1;
    @(negedge i_sys_clk);
    chk("wake", 32'(o_wake), 32'h1);
    @(posedge i_sys_clk);
    i_sleep <= 1'b0;
    rdchk(dcc_pkg::ADDR_CTRL, 32'hC2);
    wr(dcc_pkg::ADDR_CTRL, 32'h32, r);
    rdchk(dcc_pkg::ADDR_CTRL, 32'h32);
    // pin routing, unsynchronised, direction bits as enables
    wr(dcc_pkg::ADDR_CTRL, 32'h13, r);
    chk("pins", 32'({o_porta_line5, o_porta_line4}), 32'h2);
    chk("oe", 32'({o_porta_line5_oe, o_porta_line4_oe}), 32'h3);
    c1n <= 8'hFA;
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("pin4_fast", 32'(o_porta_line4), 32'h1);
    @(posedge i_sys_clk);
    wr(dcc_pkg::ADDR_DIR, 32'h3F, r);
    chk("oe_off", 32'({o_porta_line5_oe, o_porta_line4_oe}), 32'h0);
    // every mode with the input switch set, then cleared in mode 110
    for (int m = 0; m < 8; m++) begin
      wr(dcc_pkg::ADDR_CTRL, 32'h08 | 32'(m), r);
      chk("ref", 32'(o_ref_to_pos), 32'(m == 6));
      chk("on1", 32'(o_cmp1_on), 32'(m != 0 && m != 7));
      chk("on2", 32'(o_cmp2_on), 32'(m > 1 && m != 7));
      if (m == 6) chk("neg_hi", 32'({o_cmp2_neg_hi, o_cmp1_neg_hi}), 32'h3);
    end
    wr(dcc_pkg::ADDR_CTRL, 32'h06, r);
    chk("neg_lo", 32'({o_cmp2_neg_hi, o_cmp1_neg_hi}), 32'h0);
    // second reset in mid-run
    wr(dcc_pkg::ADDR_CTRL, 32'h3A, r);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    @(posedge i_sys_clk);
    rdchk(dcc_pkg::ADDR_CTRL, 32'h07);
    rdchk(dcc_pkg::ADDR_FLAG, 32'h00);
    wrap_up();
  end
endmodule : dual_comparator_control_bench
